// ---- hdl/sdcm_top.sv ----
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "sdcm_defs.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] Any write to master clear resets the socket DMA controller registers.
// [R2] Master clear fires on the write alone; data ignored, reads return zero.
// [R3] Mask register: bit 0 read/write, bits 7..1 read zero.
// [R4] Mask set ignores card requests; mask clear services them normally.
// [R5] Mask bit resets to zero; register reads 00h after reset.
// [R6] Card removal sets the mask bit automatically.
// [R7] Software must clear the controller or rewrite mask after removal.
// [R8] Request status bits follow the card request regardless of mask.
module sdcm_top #(
   // status byte split
   parameter int REQ_W = 4,
   parameter int TC_W = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   // register port
   input wire sdcm_pkg::sdcm_addr_t reg_addr,
   input wire sdcm_pkg::sdcm_data_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output sdcm_pkg::sdcm_data_t reg_rdata,
   // card side
   input wire logic card_present,
   input wire logic card_dreq,
   input wire logic xfer_tc,
   // transfer engine side
   output logic dma_service_req,
   output logic ctrl_reset
);
   import sdcm_pkg::*;

   logic channel_mask_select;
   logic next_mask;
   logic [TC_W-1:0] tc_status;
   logic removed_flag;
   logic card_removed;
   logic clear_hit;
   logic mask_wr;
   logic status_rd;
   logic ctrl_rd;
   sdcm_state_t state;
   sdcm_state_t next_state;
   sdcm_data_t next_rdata;

   //////////////////////////////////////////////////////////////////////////
   // parameter check

   // status fields must fill exactly one register byte
   if (REQ_W + TC_W != 8 || REQ_W < 1 || TC_W < 1) begin : g_bad_status_split
      $error("status field widths must fill one byte");
   end

   //////////////////////////////////////////////////////////////////////////
   // helpers

   // true when the strobe's address names this register
   function automatic logic hit(input sdcm_addr_t a, input sdcm_addr_t ofs);
      return a == ofs;
   endfunction

   // one flag at bit 0 of an otherwise empty byte
   function automatic sdcm_data_t flag_byte(input logic b);
      return {7'h00, b};
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // decode

   // any data value written to the clear offset fires the clear
   assign clear_hit = reg_wr & hit(reg_addr, `SDCM_OFS_MASTER_CLEAR); // [R2]
   assign mask_wr = reg_wr & hit(reg_addr, `SDCM_OFS_CHANNEL_MASK);
   assign status_rd = reg_rd & hit(reg_addr, `SDCM_OFS_STATUS);
   assign ctrl_rd = reg_rd & hit(reg_addr, `SDCM_OFS_CTRL);

   sdcm_card_detect u_detect (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .card_present(card_present),
      .card_removed(card_removed)
   );

   //////////////////////////////////////////////////////////////////////////
   // channel mask

   // removal wins over a simultaneous software write or clear
   always_comb begin
      next_mask = channel_mask_select;
      if (card_removed) begin
         next_mask = 1'b1; // [R6]
      end else if (clear_hit) begin
         next_mask = `SDCM_MASK_RESET; // [R1]
      end else if (mask_wr) begin
         next_mask = reg_wdata[`SDCM_MASK_BIT]; // [R3]
      end
   end

   // frozen while clk_en is low like every other register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         channel_mask_select <= `SDCM_MASK_RESET; // [R5]
      end else if (clk_en) begin
         channel_mask_select <= next_mask;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // terminal count status, cleared by read or master clear

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tc_status <= TC_W'(`SDCM_TC_RESET);
      end else if (clk_en) begin
         if (xfer_tc) begin
            tc_status <= '1;
         end else if (clear_hit || status_rd) begin
            tc_status <= TC_W'(`SDCM_TC_RESET); // [R1]
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // sticky removal flag, cleared by reading it or master clear

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         removed_flag <= 1'b0;
      end else if (clk_en) begin
         if (card_removed) begin
            removed_flag <= 1'b1;
         end else if (clear_hit || ctrl_rd) begin
            removed_flag <= 1'b0; // [R1]
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // controller state

   always_comb begin
      next_state = state;
      unique case (state)
         SDCM_ST_IDLE: begin
            if (card_dreq && !channel_mask_select) begin
               next_state = SDCM_ST_SERVICE; // [R4]
            end
         end
         SDCM_ST_SERVICE: begin
            if (!card_dreq || channel_mask_select) begin
               next_state = SDCM_ST_IDLE; // [R4]
            end
         end
         SDCM_ST_CLEAR: begin
            next_state = SDCM_ST_IDLE;
         end
         default: begin
            next_state = SDCM_ST_IDLE;
         end
      endcase
      if (clear_hit) begin
         next_state = SDCM_ST_CLEAR; // [R1]
      end
   end

   // a clear holds one cycle and drops any service in progress
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= SDCM_ST_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs to the transfer engine

   // service drops at once when the mask rises, not a cycle later
   assign dma_service_req = (state == SDCM_ST_SERVICE) & card_dreq & ~channel_mask_select; // [R4]
   assign ctrl_reset = (state == SDCM_ST_CLEAR); // [R1]

   //////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe; unmapped reads zero

   always_comb begin
      next_rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `SDCM_OFS_CHANNEL_MASK: begin
               next_rdata = flag_byte(channel_mask_select); // [R3]
            end
            // live request line, mask or not
            `SDCM_OFS_STATUS: begin
               next_rdata = {{REQ_W{card_dreq}}, tc_status}; // [R8]
            end
            `SDCM_OFS_CTRL: begin
               next_rdata = flag_byte(removed_flag);
            end
            `SDCM_OFS_MASTER_CLEAR: begin
               next_rdata = 8'h00; // [R2]
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   // registered so the data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= next_rdata;
      end
   end
endmodule

// ---- common/sdcm_defs.svh ----
`ifndef SDCM_DEFS_SVH
`define SDCM_DEFS_SVH

// register offsets
`define SDCM_OFS_STATUS 4'h8
`define SDCM_OFS_MASTER_CLEAR 4'hD
`define SDCM_OFS_CHANNEL_MASK 4'hF
`define SDCM_OFS_CTRL 4'h7

// field positions
`define SDCM_MASK_BIT 0
`define SDCM_STAT_REQ_LO 4
`define SDCM_STAT_REQ_HI 7
`define SDCM_STAT_TC_LO 0
`define SDCM_STAT_TC_HI 3
`define SDCM_CTRL_REMOVED_BIT 0

// reset values
`define SDCM_MASK_RESET 1'h0
`define SDCM_TC_RESET 4'h0

`endif

// ---- common/sdcm_pkg.sv ----
package sdcm_pkg;
   typedef logic [3:0] sdcm_addr_t;
   typedef logic [7:0] sdcm_data_t;
   typedef enum logic [1:0] {
      SDCM_ST_IDLE = 2'b00,
      SDCM_ST_SERVICE = 2'b01,
      SDCM_ST_CLEAR = 2'b10
   } sdcm_state_t;
endpackage

// ---- hdl/sdcm_card_detect.sv ----
`timescale 1ns/1ps
`include "sdcm_defs.svh"

module sdcm_card_detect (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   // card presence
   input wire logic card_present,
   output logic card_removed
);
   import sdcm_pkg::*;

   logic present_q;

   // present level seen last cycle; starts absent so no false removal
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         present_q <= 1'b0;
      end else if (clk_en) begin
         present_q <= card_present;
      end
   end

   // falling edge of presence is one removal event
   assign card_removed = clk_en & present_q & ~card_present;
endmodule

// ---- verification/sdcm_properties.sv ----
`timescale 1ns/1ps
module sdcm_props (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire sdcm_pkg::sdcm_addr_t reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire sdcm_pkg::sdcm_data_t reg_rdata,
   input wire logic card_present,
   input wire logic card_dreq,
   input wire logic dma_service_req,
   input wire logic ctrl_reset
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_rd_idle: assert property ($past(clk_en && !reg_rd) |-> reg_rdata == 8'h00) else $error("idle");
   a_mask_bits: assert property ($past(clk_en && reg_rd && reg_addr == 4'hF) |-> reg_rdata[7:1] == 7'h00) else $error("m");
   a_clr_wo: assert property ($past(clk_en && reg_rd && reg_addr == 4'hD) |-> reg_rdata == 8'h00) else $error("wo");
   a_clr_pulse: assert property (clk_en && reg_wr && reg_addr == 4'hD |=> ctrl_reset) else $error("clr");
   a_svc_dreq: assert property (dma_service_req |-> card_dreq) else $error("svc");
   a_remove_mask: assert property (clk_en && $fell(card_present) |=> !dma_service_req) else $error("rm");
   a_req_status: assert property ($past(clk_en && reg_rd && reg_addr == 4'h8) |-> reg_rdata[7:4] == {4{$past(card_dreq)}})
      else $error("st");
   a_rst_quiet: assert property ($past(sys_rst) |-> reg_rdata == 8'h00 && !ctrl_reset && !dma_service_req) else $error("rst");
   cover property (ctrl_reset);
   cover property (dma_service_req);
   cover property ($fell(card_present));
endmodule
bind sdcm_top sdcm_props u_props (.*);

// ---- verification/sdcm_card_model.sv ----
`timescale 1ns/1ps
module sdcm_card_model (
   input wire logic clk_sys,
   input wire logic insert,
   input wire logic want_req,
   output logic card_present,
   output logic card_dreq
);
   // an absent card leaves the pulled-down request low
   always @(posedge clk_sys) begin
      card_present <= insert;
      card_dreq <= insert && want_req;
   end
endmodule

// ---- verification/sdcm_top_test.sv ----
`timescale 1ns/1ps
module sdcm_top_test;
   import sdcm_pkg::*;
   logic clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, xfer_tc = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, insert = 1'b1, want_req = 1'b0;
   logic card_present, card_dreq, dma_service_req, ctrl_reset;
   sdcm_addr_t reg_addr = 4'h0;
   sdcm_data_t reg_wdata = 8'h00, reg_rdata;
   int error_cnt = 0, n_tests = 0;
   sdcm_top dut (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .card_present(card_present),
      .card_dreq(card_dreq),
      .xfer_tc(xfer_tc),
      .dma_service_req(dma_service_req),
      .ctrl_reset(ctrl_reset)
   );
   sdcm_card_model card (
      .clk_sys(clk_sys),
      .insert(insert),
      .want_req(want_req),
      .card_present(card_present),
      .card_dreq(card_dreq)
   );
   initial forever #50 clk_sys = ~clk_sys;
   task automatic chk(input sdcm_data_t s, input sdcm_data_t e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic wr(input sdcm_addr_t a, input sdcm_data_t d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rdc(input sdcm_addr_t a, input sdcm_data_t e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge clk_sys);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (400) @(posedge clk_sys);
      error_cnt++;
      print_verdict;
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rdc(4'hF, 8'h00);
      rdc(4'hD, 8'h00);
      rdc(4'h8, 8'h00);
      wr(4'hF, 8'hFF);
      rdc(4'hF, 8'h01);
      xfer_tc <= 1'b1;
      @(posedge clk_sys);
      xfer_tc <= 1'b0;
      rdc(4'h8, 8'h0F);
      rdc(4'h8, 8'h00);
      xfer_tc <= 1'b1;
      @(posedge clk_sys);
      xfer_tc <= 1'b0;
      reg_addr <= 4'hD;
      reg_wdata <= 8'h5A;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1 chk({7'h00, ctrl_reset}, 8'h01);
      @(posedge clk_sys);
      #1 chk({7'h00, ctrl_reset}, 8'h00);
      @(posedge clk_sys);
      rdc(4'hF, 8'h00);
      rdc(4'h8, 8'h00);
      clk_en <= 1'b0;
      wr(4'hF, 8'h01);
      clk_en <= 1'b1;
      rdc(4'hF, 8'h00);
      $display("test registers end");
      want_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 chk({7'h00, dma_service_req}, 8'h01);
      @(posedge clk_sys);
      wr(4'hF, 8'h01);
      #1 chk({7'h00, dma_service_req}, 8'h00);
      @(posedge clk_sys);
      rdc(4'h8, 8'hF0);
      $display("test service end");
      wr(4'hF, 8'h00);
      insert <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rdc(4'hF, 8'h01);
      rdc(4'h7, 8'h01);
      rdc(4'h7, 8'h00);
      wr(4'hF, 8'h00);
      rdc(4'hF, 8'h00);
      wr(4'hF, 8'h01);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rdc(4'hF, 8'h00);
      $display("test removal end");
      print_verdict;
   end
endmodule
